//--- inc/flc_pkg.sv
package flc_pkg;

  // ----------------------------------------------------------------
  // Code groups
  // ----------------------------------------------------------------
  localparam logic [4:0] CG_IDLE    = 5'h1f; // 11111
  localparam logic [4:0] CG_SSD1    = 5'h18; // 11000
  localparam logic [4:0] CG_SSD2    = 5'h11; // 10001
  localparam logic [4:0] CG_ESD1    = 5'h0d; // 01101
  localparam logic [4:0] CG_ESD2    = 5'h07; // 00111
  localparam logic [4:0] CG_TXERR   = 5'h04; // 00100
  localparam logic [9:0] CG_SSD_PAIR = {CG_SSD1, CG_SSD2};

  // ----------------------------------------------------------------
  // Line coding and scrambler
  // ----------------------------------------------------------------
  localparam int         CG_BITS      = 5;
  localparam logic [2:0] CG_LAST_BIT  = 3'h4;
  localparam int         SCR_LEN      = 11;
  localparam int         SCR_TAP_A    = 8;  // history taps, x^9 and x^11
  localparam int         SCR_TAP_B    = 10;
  localparam logic [10:0] SCR_RST     = 11'h000;
  localparam logic       NRZI_RST     = 1'b0;
  localparam logic [1:0] MLT3_STEP_RST = 2'h0; // lowest level
  localparam logic [1:0] MLT3_LOW     = 2'h0;
  localparam logic [1:0] MLT3_MID     = 2'h1;
  localparam logic [1:0] MLT3_HIGH    = 2'h2;

  // ----------------------------------------------------------------
  // Frame layout, counted in nibbles after the start delimiter
  // ----------------------------------------------------------------
  localparam int PRE_OCTETS   = 8;
  localparam int ADDR_OCTETS  = 6;
  localparam int LEN_OCTETS   = 2;
  localparam int PAY_MIN      = 46;
  localparam int PAY_MAX      = 1500;
  localparam int CRC_OCTETS   = 4;
  localparam int HDR_NIBS     = 2 * PRE_OCTETS - 2 + 2 * (2 * ADDR_OCTETS + LEN_OCTETS);
  localparam logic [11:0] FRM_NIB_MIN = 12'(HDR_NIBS + 2 * (PAY_MIN + CRC_OCTETS));
  localparam logic [11:0] FRM_NIB_MAX = 12'(HDR_NIBS + 2 * (PAY_MAX + CRC_OCTETS));

  // ----------------------------------------------------------------
  // FIFO and carriers
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic       sof;    // first preamble nibble of a frame
    logic       eof;    // last nibble of a frame
    logic       err;    // transmit error on this nibble
    logic [3:0] nibble;
  } flc_tx_word_t;

  typedef struct packed {
    logic       valid;   // nibble holds decoded data
    logic       sof;     // start delimiter pair seen
    logic       eof;     // end delimiter pair seen
    logic       txerr;   // propagated transmit error code
    logic       invalid; // undefined code group
    logic       len_err; // frame size out of range, with eof
    logic [3:0] nibble;
  } flc_rx_word_t;

  typedef enum logic [2:0] {TX_IDLE, TX_SSD2, TX_DATA, TX_ESD1, TX_ESD2} flc_tx_state_t;

endpackage

//--- verilog/flc_codec.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Word FIFO with valid/ready on both sides
// ------------------------------------------------------------------
module flc_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             ready_r;
  logic             push;
  logic             pop;

  // Registered not-full, honest empty
  assign in_ready  = ready_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

  // Storage
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop)
        rd_ptr_r <= rd_ptr_r + AW'(1);
      count_r <= count_nxt;
      ready_r <= (count_nxt != (AW+1)'(DEPTH)); // Not full next cycle
    end
  end
endmodule

// Behaviour
// - TX and FX both use 4B/5B coding on transmit, decoding on receive.
// - Each transmit data nibble becomes its fixed 5-bit code group.
// - Receive data code groups map back to nibbles, exact inverse.
// - Frame start sends 11000 then 10001 instead of two preamble nibbles.
// - After the last nibble send 01101 then 00111; receiver ends frame.
// - Idle 11111 sent between frames; receiver treats it as idle.
// - Transmit error sends 00100; receiver reports propagated error.
// - Undefined received code groups are flagged invalid.
// - Serial code stream is NRZI: toggle on one, hold on zero.
// - In TX mode NRZI is further coded as MLT3.
// - MLT3 steps low, mid, high, mid per NRZI transition, repeating.
// - TX mode scrambles before MLT3 and descrambles on receive.
// - Frame starts with 8 preamble octets, two addresses and length.
// - Payload carries 46 to 1500 octets.
// - Frame data ends with a 4-octet CRC.
// - End delimiter follows CRC, then variable idle.
module flc_codec
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  mode_tx,
  input  wire logic                  mac_tx_valid,
  output logic                       mac_tx_ready,
  input  wire flc_pkg::flc_tx_word_t mac_tx_word,
  output logic                       line_tx_nrzi_r,
  output logic [1:0]                 line_tx_mlt3_r,
  input  wire logic                  line_rx_nrzi,
  input  wire logic [1:0]            line_rx_mlt3,
  output flc_pkg::flc_rx_word_t      mac_rx_word_r
);
  import flc_pkg::*;

  // ----------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------

  // Nibble to data code group
  function automatic logic [4:0] enc5(input logic [3:0] nib);
    logic [4:0] cg;
    cg = 5'h1e;
    unique case (nib)
      4'h0: cg = 5'h1e;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0a;
      4'h5: cg = 5'h0b;
      4'h6: cg = 5'h0e;
      4'h7: cg = 5'h0f;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'ha: cg = 5'h16;
      4'hb: cg = 5'h17;
      4'hc: cg = 5'h1a;
      4'hd: cg = 5'h1b;
      4'he: cg = 5'h1c;
      4'hf: cg = 5'h1d;
    endcase
    return cg;
  endfunction

  // Data code group to {is_data, nibble}
  function automatic logic [4:0] dec5(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (enc5(4'(i)) == cg)
        r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  flc_tx_word_t head;
  logic         head_valid;
  logic         head_pop;

  flc_fifo #(
    .WIDTH ($bits(flc_tx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (mac_tx_valid),
    .in_ready  (mac_tx_ready),
    .in_data   (mac_tx_word),
    .out_valid (head_valid),
    .out_ready (head_pop),
    .out_data  (head)
  );

  // ----------------------------------------------------------------
  // Transmit code group sequencer
  // ----------------------------------------------------------------
  flc_tx_state_t tx_state_r;
  flc_tx_state_t tx_state_nxt;
  logic [2:0]    tx_bit_r;
  logic [4:0]    tx_sh_r;
  logic [4:0]    tx_cg_nxt;
  logic          grp_load;

  // A new group is chosen while the last bit of the old one leaves
  assign grp_load = (tx_bit_r == CG_LAST_BIT);

  // Group selection; the FIFO drains only at group boundaries
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    tx_cg_nxt    = CG_IDLE;
    head_pop     = 1'b0;
    unique case (tx_state_r)
      TX_IDLE:
      begin
        tx_cg_nxt = CG_IDLE;
        if (head_valid && !head.sof)
          head_pop = grp_load; // stray nibble outside a frame
        else if (head_valid)
        begin
          tx_cg_nxt    = CG_SSD1;
          head_pop     = grp_load;
          tx_state_nxt = TX_SSD2;
        end
      end
      TX_SSD2:
      begin
        tx_cg_nxt    = CG_SSD2;
        head_pop     = grp_load && head_valid;
        tx_state_nxt = TX_DATA;
      end
      TX_DATA:
      begin
        if (head_valid)
        begin
          head_pop = grp_load;
          tx_cg_nxt = head.err ? CG_TXERR : enc5(head.nibble);
          if (head.eof)
            tx_state_nxt = TX_ESD1;
        end
        else
          tx_cg_nxt = CG_TXERR; // underrun corrupts the frame
      end
      TX_ESD1:
      begin
        // end pair after the last nibble
        // end of stream after the check field
        tx_cg_nxt    = CG_ESD1;
        tx_state_nxt = TX_ESD2;
      end
      TX_ESD2:
      begin
        tx_cg_nxt    = CG_ESD2;
        tx_state_nxt = TX_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tx_state_r <= TX_IDLE;
    else if (grp_load)
      tx_state_r <= tx_state_nxt;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_bit_r <= 3'h0;
      tx_sh_r  <= CG_IDLE;
    end
    else if (grp_load)
    begin
      tx_bit_r <= 3'h0;
      tx_sh_r  <= tx_cg_nxt;
    end
    else
    begin
      tx_bit_r <= tx_bit_r + 3'h1;
      tx_sh_r  <= {tx_sh_r[3:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Transmit scrambler, NRZI and MLT3
  // ----------------------------------------------------------------
  logic [SCR_LEN-1:0] tx_scr_r;
  logic               tx_bit;
  logic               tx_scr_bit;
  logic [1:0]         mlt3_step_r;

  assign tx_bit     = tx_sh_r[4];
  // self-synchronising scrambling in TX mode only
  assign tx_scr_bit = mode_tx ? (tx_bit ^ tx_scr_r[SCR_TAP_A] ^ tx_scr_r[SCR_TAP_B])
                              : tx_bit;

  // Scrambler history
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tx_scr_r <= SCR_RST;
    else
      tx_scr_r <= {tx_scr_r[SCR_LEN-2:0], tx_scr_bit};
  end

  // toggle on one, hold on zero
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      line_tx_nrzi_r <= NRZI_RST;
    else if (tx_scr_bit)
      line_tx_nrzi_r <= ~line_tx_nrzi_r;
  end

  // one step per NRZI transition, low mid high mid
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mlt3_step_r <= MLT3_STEP_RST;
    else if (!mode_tx)
      mlt3_step_r <= MLT3_STEP_RST; // Matches the held low level
    else if (tx_scr_bit)
      mlt3_step_r <= mlt3_step_r + 2'h1;
  end

  // MLT3 level driven in TX mode, held low in FX mode
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      line_tx_mlt3_r <= MLT3_LOW;
    else if (!mode_tx)
      line_tx_mlt3_r <= MLT3_LOW;
    else if (tx_scr_bit)
    begin
      unique case (mlt3_step_r)
        2'h0: line_tx_mlt3_r <= MLT3_MID;
        2'h1: line_tx_mlt3_r <= MLT3_HIGH;
        2'h2: line_tx_mlt3_r <= MLT3_MID;
        2'h3: line_tx_mlt3_r <= MLT3_LOW;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive line decoding and descrambler
  // ----------------------------------------------------------------
  logic               rx_nrzi_prev_r;
  logic [1:0]         rx_mlt3_prev_r;
  logic [SCR_LEN-1:0] rx_scr_r;
  logic               rx_line_bit;
  logic               rx_bit;

  // Any level change on the active medium (MLT3 in TX mode, NRZI in FX mode) is a one bit
  assign rx_line_bit = mode_tx ? (line_rx_mlt3 != rx_mlt3_prev_r)
                               : (line_rx_nrzi != rx_nrzi_prev_r);
  assign rx_bit = mode_tx ? (rx_line_bit ^ rx_scr_r[SCR_TAP_A] ^ rx_scr_r[SCR_TAP_B])
                          : rx_line_bit;

  // Previous line levels and descrambler history
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_nrzi_prev_r <= NRZI_RST;
      rx_mlt3_prev_r <= MLT3_LOW;
      rx_scr_r       <= SCR_RST;
    end
    else
    begin
      rx_nrzi_prev_r <= line_rx_nrzi;
      rx_mlt3_prev_r <= line_rx_mlt3;
      rx_scr_r       <= {rx_scr_r[SCR_LEN-2:0], rx_line_bit};
    end
  end

  // ----------------------------------------------------------------
  // Receive alignment and group decoding
  // ----------------------------------------------------------------
  logic [9:0]  rx_sh_r;
  logic [9:0]  rx_sh_nxt;
  logic [2:0]  rx_cnt_r;
  logic        aligned_r;
  logic        esd_half_r;
  logic [11:0] nib_cnt_r;
  logic [4:0]  rx_cg;
  logic [4:0]  rx_dec;
  logic        grp_done;
  logic        ssd_hit;

  assign rx_sh_nxt = {rx_sh_r[8:0], rx_bit};
  assign rx_cg     = rx_sh_nxt[4:0];
  assign rx_dec    = dec5(rx_cg);
  assign grp_done  = aligned_r && (rx_cnt_r == CG_LAST_BIT);
  assign ssd_hit   = !aligned_r && (rx_sh_nxt == CG_SSD_PAIR);

  // Bit history
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rx_sh_r <= {CG_IDLE, CG_IDLE};
    else
      rx_sh_r <= rx_sh_nxt;
  end

  // align on start pair, drop on end pair or idle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aligned_r  <= 1'b0;
      rx_cnt_r   <= 3'h0;
      esd_half_r <= 1'b0;
    end
    else if (ssd_hit)
    begin
      aligned_r  <= 1'b1;
      rx_cnt_r   <= 3'h0;
      esd_half_r <= 1'b0;
    end
    else if (grp_done)
    begin
      rx_cnt_r   <= 3'h0;
      esd_half_r <= (rx_cg == CG_ESD1);
      if (rx_cg == CG_IDLE || (esd_half_r && rx_cg == CG_ESD2))
        aligned_r <= 1'b0;
    end
    else if (aligned_r)
      rx_cnt_r <= rx_cnt_r + 3'h1;
  end

  // Data nibbles received since the start pair
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      nib_cnt_r <= 12'h000;
    else if (ssd_hit)
      nib_cnt_r <= 12'h000;
    else if (grp_done && rx_dec[4] && nib_cnt_r != 12'hfff)
      nib_cnt_r <= nib_cnt_r + 12'h001;
  end

  // Decoded word towards the MAC, one-cycle flags
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mac_rx_word_r <= '0;
    else
    begin
      mac_rx_word_r <= '0;
      mac_rx_word_r.sof <= ssd_hit;
      if (grp_done)
      begin
        mac_rx_word_r.valid  <= rx_dec[4];
        mac_rx_word_r.nibble <= rx_dec[3:0];
        mac_rx_word_r.txerr  <= (rx_cg == CG_TXERR);
        // neither data nor a defined control code
        mac_rx_word_r.invalid <= !rx_dec[4] && rx_cg != CG_IDLE && rx_cg != CG_TXERR
                                 && rx_cg != CG_ESD1 && rx_cg != CG_ESD2
                                 && rx_cg != CG_SSD1 && rx_cg != CG_SSD2;
        if (esd_half_r && rx_cg == CG_ESD2)
        begin
          mac_rx_word_r.eof <= 1'b1;
          mac_rx_word_r.len_err <= (nib_cnt_r < FRM_NIB_MIN) || (nib_cnt_r > FRM_NIB_MAX);
        end
      end
    end
  end
endmodule

//--- tb/flc_codec_properties.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module flc_codec_properties
(
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  mode_tx,
  input wire logic                  mac_tx_valid,
  input wire logic                  mac_tx_ready,
  input wire flc_pkg::flc_tx_word_t mac_tx_word,
  input wire logic                  line_tx_nrzi_r,
  input wire logic [1:0]            line_tx_mlt3_r,
  input wire logic                  line_rx_nrzi,
  input wire logic [1:0]            line_rx_mlt3,
  input wire flc_pkg::flc_rx_word_t mac_rx_word_r
);
  import flc_pkg::*;

  logic [1:0] last_ext_r;
  logic [1:0] rel_cnt_r;
  logic       no_push_r;
  logic       rx_lvl_r;
  logic [9:0] rx_hist_r;
  logic [4:0] flags;

  // Rx event flags
  assign flags = {mac_rx_word_r.valid, mac_rx_word_r.sof, mac_rx_word_r.eof,
                  mac_rx_word_r.txerr, mac_rx_word_r.invalid};

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Last extreme MLT3 level
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      last_ext_r <= MLT3_LOW;
    else if (line_tx_mlt3_r != MLT3_MID)
      last_ext_r <= line_tx_mlt3_r;

  // Cycles since reset, nothing taken yet
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      rel_cnt_r <= 2'h0;
      no_push_r <= 1'b1;
    end
    else
    begin
      if (rel_cnt_r != 2'h3)
        rel_cnt_r <= rel_cnt_r + 2'h1;
      if (mac_tx_valid && mac_tx_ready)
        no_push_r <= 1'b0;
    end

  // Received bits, NRZI reading
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      rx_lvl_r  <= 1'b0;
      rx_hist_r <= 10'h000;
    end
    else
    begin
      rx_lvl_r  <= line_rx_nrzi;
      rx_hist_r <= {rx_hist_r[8:0], line_rx_nrzi ^ rx_lvl_r};
    end

  a_fx_mlt3_low:
    assert property (!mode_tx && !$past(mode_tx) |-> line_tx_mlt3_r == MLT3_LOW)
      else $error("mlt3 not low in fx mode");
  a_mlt3_level:
    assert property (line_tx_mlt3_r != 2'h3)
      else $error("mlt3 level undefined");
  a_mlt3_moves:
    assert property (mode_tx && $past(mode_tx)
      |-> $changed(line_tx_nrzi_r) == $changed(line_tx_mlt3_r))
      else $error("mlt3 step not tied to nrzi transition");
  a_mlt3_turn:
    assert property (mode_tx && $past(mode_tx) && $past(line_tx_mlt3_r) == MLT3_MID
      && line_tx_mlt3_r != MLT3_MID |-> line_tx_mlt3_r != last_ext_r)
      else $error("mlt3 did not reverse direction");
  a_idle_after_rst:
    assert property (!mode_tx && !$past(mode_tx) && no_push_r && rel_cnt_r == 2'h3
      |-> line_tx_nrzi_r != $past(line_tx_nrzi_r))
      else $error("idle ones not toggling nrzi");
  a_rx_group_gap:
    assert property (|flags |=> !(|flags) [*4])
      else $error("rx events closer than one group");
  a_rx_one_event:
    assert property ($onehot0(flags))
      else $error("several rx events at once");
  a_len_with_eof:
    assert property (mac_rx_word_r.len_err |-> mac_rx_word_r.eof)
      else $error("len_err without eof");
  a_sof_pair:
    assert property (!mode_tx && mac_rx_word_r.sof
      |-> rx_hist_r == CG_SSD_PAIR || $past(rx_hist_r) == CG_SSD_PAIR)
      else $error("sof without start pair");
  a_ready_back:
    assert property ($fell(mac_tx_ready) |-> ##[1:20] mac_tx_ready)
      else $error("tx fifo never drained");
endmodule

bind flc_codec flc_codec_properties flc_codec_properties_inst (
  .sys_clk(sys_clk), .rst(rst), .mode_tx(mode_tx), .mac_tx_valid(mac_tx_valid),
  .mac_tx_ready(mac_tx_ready), .mac_tx_word(mac_tx_word),
  .line_tx_nrzi_r(line_tx_nrzi_r), .line_tx_mlt3_r(line_tx_mlt3_r),
  .line_rx_nrzi(line_rx_nrzi), .line_rx_mlt3(line_rx_mlt3),
  .mac_rx_word_r(mac_rx_word_r));

//--- tb/flc_line_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Line side: one-cycle loopback cable, or injected code bits on the NRZI line only
// ----------------------------------------------------------------
module flc_line_model
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       tx_nrzi,
  input  wire logic [1:0] tx_mlt3,
  input  wire logic       inj_en,
  input  wire logic       inj_bit,
  output logic            rx_nrzi,
  output logic [1:0]      rx_mlt3
);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      rx_nrzi <= 1'b0;
    else if (inj_en)
      rx_nrzi <= rx_nrzi ^ inj_bit;
    else
      rx_nrzi <= tx_nrzi;

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      rx_mlt3 <= 2'h0;
    else
      rx_mlt3 <= tx_mlt3;
endmodule

//--- tb/tb_fast_ethernet_line_codec.sv
`timescale 1ns/1ps

module tb_fast_ethernet_line_codec;
  import flc_pkg::*;

  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         mode_tx = 1'b0;
  logic         mac_tx_valid = 1'b0;
  logic         mac_tx_ready;
  flc_tx_word_t mac_tx_word = '0;
  logic         line_tx_nrzi_r;
  logic [1:0]   line_tx_mlt3_r;
  logic         line_rx_nrzi;
  logic [1:0]   line_rx_mlt3;
  flc_rx_word_t mac_rx_word_r;
  logic         inj_en = 1'b0;
  logic         inj_bit = 1'b0;
  logic         lerr_r = 1'b0;
  int           bad_count = 0;
  int           checked = 0;
  int           cycles = 0;
  int           sof_n, eof_n, inv_n, txe_n, full_n, mlt3_nz;
  logic [3:0]   rx_q[$];
  logic [3:0]   exp_q[$];

  flc_codec flc_codec_inst (
    .sys_clk(sys_clk), .rst(rst), .mode_tx(mode_tx), .mac_tx_valid(mac_tx_valid),
    .mac_tx_ready(mac_tx_ready), .mac_tx_word(mac_tx_word),
    .line_tx_nrzi_r(line_tx_nrzi_r), .line_tx_mlt3_r(line_tx_mlt3_r),
    .line_rx_nrzi(line_rx_nrzi), .line_rx_mlt3(line_rx_mlt3),
    .mac_rx_word_r(mac_rx_word_r));

  flc_line_model flc_line_model_inst (
    .sys_clk(sys_clk), .rst(rst), .tx_nrzi(line_tx_nrzi_r), .tx_mlt3(line_tx_mlt3_r),
    .inj_en(inj_en), .inj_bit(inj_bit), .rx_nrzi(line_rx_nrzi), .rx_mlt3(line_rx_mlt3));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
  begin
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  end
  endtask

  // Rx event log and run limit
  always @(negedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      wrap_up();
    end
    if (!rst)
    begin
      mlt3_nz += (line_tx_mlt3_r !== 2'h0);
      sof_n += mac_rx_word_r.sof;
      inv_n += mac_rx_word_r.invalid;
      txe_n += mac_rx_word_r.txerr;
      if (mac_rx_word_r.valid)
        rx_q.push_back(mac_rx_word_r.nibble);
      if (mac_rx_word_r.eof)
      begin
        eof_n++;
        lerr_r = mac_rx_word_r.len_err;
      end
    end
  end

  // Offer one word, hold it until taken
  task automatic push(input flc_tx_word_t w);
    int n;
  begin
    n = 0;
    mac_tx_word = w;
    mac_tx_valid = 1'b1;
    while (mac_tx_ready !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    full_n += (n > 0);
    @(negedge sys_clk);
  end
  endtask

  task automatic clear_log();
  begin
    rx_q.delete();
    exp_q.delete();
    sof_n = 0;
    eof_n = 0;
    inv_n = 0;
    txe_n = 0;
    full_n = 0;
    mlt3_nz = 0;
  end
  endtask

  task automatic wait_eof();
    int n;
  begin
    n = 0;
    while (eof_n < 1 && n < 500)
    begin
      @(negedge sys_clk);
      n++;
    end
  end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic idle_chk();
    int t;
    logic p;
  begin
    t = 0;
    repeat (3) @(negedge sys_clk);
    repeat (10)
    begin
      p = line_tx_nrzi_r;
      @(negedge sys_clk);
      t += (line_tx_nrzi_r !== p);
    end
    chk(t, 10);
  end
  endtask

  task automatic frame_chk(input int n, input int err_i);
    flc_tx_word_t w;
  begin
    clear_log();
    for (int k = 0; k < n; k++)
    begin
      w.sof = (k == 0);
      w.eof = (k == n - 1);
      w.err = (k == err_i);
      w.nibble = (k < 16) ? 4'h5 : k[3:0];
      push(w);
      if (k >= 2 && k != err_i)
        exp_q.push_back(w.nibble);
    end
    mac_tx_valid = 1'b0;
    wait_eof();
    chk(sof_n, 1);
    chk(eof_n, 1);
    chk(txe_n, err_i >= 0);
    chk(lerr_r, n - 2 < FRM_NIB_MIN);
    chk(mlt3_nz > 0, mode_tx);
    chk(full_n > 0, n > 100);
    chk(rx_q.size(), exp_q.size());
    foreach (exp_q[i])
      if (i < rx_q.size())
        chk(rx_q[i], exp_q[i]);
    repeat (20) @(negedge sys_clk);
  end
  endtask

  task automatic inj_chk();
    logic [4:0] g[20] = '{CG_IDLE, CG_IDLE, CG_SSD1, CG_SSD2, 5'h00, 5'h01, 5'h02,
      5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19, CG_TXERR, 5'h09, CG_ESD1,
      CG_ESD2, CG_IDLE, CG_IDLE};
  begin
    clear_log();
    inj_en = 1'b1;
    foreach (g[i])
      for (int b = 4; b >= 0; b--)
      begin
        inj_bit = g[i][b];
        @(negedge sys_clk);
      end
    inj_en = 1'b0;
    wait_eof();
    chk(sof_n, 1);
    chk(inv_n, 10);
    chk(txe_n, 1);
    chk(eof_n, 1);
    chk(rx_q.size(), 1);
    if (rx_q.size() > 0)
      chk(rx_q[0], 4'h1);
  end
  endtask

  // Stray word outside a frame is dropped
  task automatic stray_chk();
    flc_tx_word_t w;
  begin
    clear_log();
    w = '0;
    w.nibble = 4'ha;
    push(w);
    mac_tx_valid = 1'b0;
    repeat (30) @(negedge sys_clk);
    chk(sof_n + eof_n + inv_n + txe_n + rx_q.size(), 0);
    chk(mac_tx_ready, 1'b1);
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(negedge sys_clk);
    chk(mac_tx_ready, 1'b1);
    chk(line_tx_nrzi_r, NRZI_RST);
    chk(line_tx_mlt3_r, MLT3_LOW);
    chk(mac_rx_word_r, 11'h000);
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    idle_chk();
    frame_chk(20, 17);
    mode_tx = 1'b1;
    // Idle long enough for the descrambler history to refill
    repeat (20) @(negedge sys_clk);
    frame_chk(144, -1);
    mode_tx = 1'b0;
    repeat (20) @(negedge sys_clk);
    inj_chk();
    stray_chk();
    idle_chk();
    wrap_up();
  end
endmodule
